// file: shared/pump_if_cfg.svh
`ifndef PUMP_IF_CFG_SVH
`define PUMP_IF_CFG_SVH
// interface memory offsets of the pump
`define OFS_TONE     5'h02
`define OFS_TRAIN    5'h04
`define OFS_SYNC     5'h0A
`define OFS_TXHOLD   5'h10
`define OFS_TXSTAT   5'h1E
// bit positions inside those bytes
`define BIT_TONE_ON  7
`define BIT_SHORT_SEL 0
`define BIT_FLAG_SEEN 0
`define BIT_IRQ_ACT  7
`define BIT_IRQ_ON   5
`define BIT_EMPTY    3
// reset values
`define RST_TXHOLD   8'h00
`define RST_TONE_ON  1'b1
`define RST_SHORT_SEL 1'b0
`define RST_IRQ_ON   1'b0
`define RST_EMPTY    1'b1
// hdlc flag byte, idle line level and serializer last bit count
`define HDLC_FLAG    8'h7E
`define MARK_LEVEL   1'b1
`define LAST_BIT     3'h7
// controller register map on axi4-lite
`define HOST_OFS_CMD  4'h0
`define HOST_OFS_STAT 4'h4
`define CMD_RD_BIT    16
`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2
`endif

// file: shared/pump_if_pkg.sv
package pump_if_pkg;
  // device end state
  typedef struct packed {
    logic [7:0] txHold;     // holding byte
    logic       holdFull;   // holding byte not yet taken
    logic       toneOn;
    logic       shortSel;   // short train select control
    logic       flagSeen;   // hdlc flag pattern being detected
    logic       irqOn;
    logic       irqAct;
    logic       irq;
    logic [7:0] rdata;
    logic       rdValid;
    logic [7:0] shifter;
    logic [2:0] bitCnt;
    logic       busy;
    logic       txBit;
    logic [2:0] toneEn;
    logic       shortTrain;
    logic       tapsHold;
    logic       shortAccept;
  } pump_state_t;

  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_phase_t;

  // controller end state
  typedef struct packed {
    host_phase_t phase;
    logic        awTaken;
    logic [3:0]  awAddr;
    logic        wTaken;
    logic [31:0] wData;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic        isRead;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  lastRead;
    logic        refused;
    logic        irqSeen;
  } host_state_t;
endpackage

// file: shared/pump_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pump_mem_if;
  logic [4:0] addr;    // interface memory address
  logic [7:0] wdata;   // write byte
  logic       wr;      // one-cycle write strobe
  logic       rd;      // one-cycle read strobe
  logic [7:0] rdata;   // read byte
  logic       rdValid; // rdata valid, one cycle
  logic       irq;     // interrupt request, level

  modport pump (input addr, wdata, wr, rd, output rdata, rdValid, irq);
  modport host (output addr, wdata, wr, rd, input rdata, rdValid, irq);
endinterface
`default_nettype wire

// file: verif/pump_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "pump_if_cfg.svh"
// passive watch of the byte port between controller and pump
module pump_link_monitor
(
  input wire logic       clk_sys, // system clock
  input wire logic       rst,     // sync reset
  input wire logic [4:0] addr,    // byte address
  input wire logic [7:0] wdata,   // write byte
  input wire logic       wr,      // write pulse
  input wire logic       rd,      // read pulse
  input wire logic [7:0] rdata,   // read byte
  input wire logic       rdValid, // read answer
  input wire logic       irq      // irq level
);
  logic       ieCopy; // shadow of the irq enable
  logic       ieRd;   // enable as seen by the last read
  logic [4:0] rdAdr;  // address of the last read
  wire holdWr = wr && addr == `OFS_TXHOLD;
  wire ieOff  = wr && addr == `OFS_TXSTAT && !wdata[`BIT_IRQ_ON];
  wire known  = rdAdr inside {`OFS_TONE, `OFS_TRAIN, `OFS_SYNC,
                              `OFS_TXHOLD, `OFS_TXSTAT};
  // shadows land on the same edge as the pump's own registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ieCopy <= 1'b0;
    else if (wr && addr == `OFS_TXSTAT)
      ieCopy <= wdata[`BIT_IRQ_ON];
    if (rd)
    begin
      rdAdr <= addr;
      ieRd  <= ieCopy;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_read_answers: assert property (rd |=> rdValid)
    else $error("read not answered in the next cycle");
  a_answer_cause: assert property (rdValid |-> $past(rd))
    else $error("read answer with no request");
  a_strobe_single: assert property
    ((wr || rd) |-> !(wr && rd) ##1 !(wr || rd))
    else $error("strobes overlap or last too long");
  a_write_drops_irq: assert property (holdWr |=> !irq)
    else $error("holding write left irq up");
  a_irq_needs_on: assert property (irq |-> ieCopy)
    else $error("irq raised while disabled");
  a_irq_holds_up: assert property ($fell(irq) |->
    $past(holdWr) || $past(ieOff) || $past(rst))
    else $error("irq dropped with no clearing cause");
  a_unmapped_zero: assert property (rdValid && !known |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_layout: assert property (rdValid && rdAdr == `OFS_TXSTAT |->
    rdata[`BIT_IRQ_ON] == ieRd && (rdata & 8'h57) == 8'h00)
    else $error("status byte layout wrong");
  c_irq_cleared: cover property (holdWr && irq);
  c_sync_read: cover property (rd && addr == `OFS_SYNC);
  c_irq_rise: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: verif/test_host_tx_buffer_and_status_bits.sv
`timescale 1ns/10ps
`default_nettype none
`include "pump_if_cfg.svh"
module test_host_tx_buffer_and_status_bits;
  logic clk_sys, rst, v17v27Sel, hdlcMode, fifoModeOn, fifoExtOn, fifoRoom;
  logic rxWindowVld, rxFirstData, txBitStrobe, txBit; // pump side pins
  logic shortTrain, tapsHold, shortAccept;  // training outputs
  logic dataMode, ctsOn, rtsOn, longTrainOk; // host status pins
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0]  rxWindow;   // last received bits
  logic [2:0]  toneEn;     // detector enables
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, st; // st: last status word
  logic [1:0]  bresp, rresp, r2;
  logic [9:0]  bits;       // model: byte then two marks
  logic        ie;         // model: irq enable
  integer      seed = 12038;
  int          num_errors = 0;
  int          n_tests = 0;
  pump_mem_if memBus ();
  pump_regs pump_regs_inst (.clk_sys, .rst, .mem(memBus), .v17v27Sel,
    .hdlcMode, .fifoModeOn, .fifoExtOn, .fifoRoom, .rxWindowVld, .rxWindow,
    .rxFirstData, .txBitStrobe, .txBit, .toneEn, .shortTrain, .tapsHold,
    .shortAccept);
  host_ctrl host_ctrl_inst (.clk_sys, .rst, .mem(memBus), .dataMode, .ctsOn,
    .rtsOn, .longTrainOk, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp);
  pump_link_monitor pump_link_monitor_inst (.clk_sys, .rst,
    .addr(memBus.addr), .wdata(memBus.wdata), .wr(memBus.wr),
    .rd(memBus.rd), .rdata(memBus.rdata), .rdValid(memBus.rdValid),
    .irq(memBus.irq));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: both channels offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one pump access, then poll until the controller is idle again
  task automatic cmd(input logic rf, input logic [4:0] a,
                     input logic [7:0] d);
    logic [1:0] r;
    int k;
    axi_wr(4'h0, {15'h0, rf, 3'h0, a, d}, r);
    chk("bresp", 32'(`AXI_OKAY), 32'(r));
    k = 0;
    do
    begin
      axi_rd(4'h4, st, r);
      k++;
    end
    while (st[0] !== 1'b0 && k < 40);
    // a poll that runs out of tries counts as a mismatch here
    chk("idle", 32'h0, 32'(st[0]));
  endtask
  task automatic rd8(input logic [4:0] a, input logic [7:0] m,
                     input logic [7:0] e, input string nm);
    cmd(1'b1, a, 8'h00);
    chk(nm, 32'(e), 32'(st[15:8] & m));
  endtask
  // one bit time; txBit is looked at once the edge has landed
  task automatic strobe();
    @(posedge clk_sys);
    txBitStrobe <= 1'b1;
    @(posedge clk_sys);
    txBitStrobe <= 1'b0;
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial
  begin
    #400000;
    num_errors++;
    $display("BAD watchdog expected done seen timeout");
    final_report();
  end
  initial
  begin
    {v17v27Sel, hdlcMode, fifoModeOn, fifoExtOn, fifoRoom} = '0;
    {rxWindowVld, rxFirstData, txBitStrobe, dataMode, longTrainOk} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {rxWindow, awaddr, araddr, wstrb, wdata} = '0;
    ctsOn = 1'b1;
    rtsOn = 1'b1;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd8(`OFS_TXSTAT, 8'hFF, 8'h08, "status");
    rd8(`OFS_TRAIN, 8'h01, 8'h00, "shortSel");
    rd8(5'h05, 8'hFF, 8'h00, "unmapped");
    $display("reset test done");
    for (int i = 0; i < 2; i++)
    begin
      cmd(1'b0, `OFS_TONE, (i == 1) ? 8'h80 : 8'h00);
      chk("toneEn", 32'(i * 7), 32'(toneEn));
    end
    v17v27Sel <= 1'b1; // config held while short train is set
    for (int i = 0; i < 3; i++)
    begin
      longTrainOk <= (i != 0);
      cmd(1'b0, `OFS_TRAIN, {7'h0, i != 2});
      chk("refused", 32'(i == 0), 32'(st[16]));
      chk("train", (i == 1) ? 32'h7 : 32'h0,
          32'({shortTrain, tapsHold, shortAccept}));
    end
    ctsOn <= 1'b0;
    cmd(1'b0, `OFS_TXHOLD, 8'h5A);
    chk("noCts", 32'h1, 32'(st[16]));
    ctsOn <= 1'b1;
    dataMode <= 1'b1;
    cmd(1'b1, `OFS_TXHOLD, 8'h00);
    chk("dataRead", 32'h1, 32'(st[16]));
    dataMode <= 1'b0;
    rd8(`OFS_TXSTAT, 8'h08, 8'h08, "stillEmpty");
    $display("control test done");
    for (int i = 0; i < 3; i++)
    begin
      ie = (i == 1);
      bits = {2'b11, 8'($random(seed))};
      cmd(1'b0, `OFS_TXHOLD, bits[7:0]);
      chk("irqCleared", 32'h0, 32'(memBus.irq));
      cmd(1'b0, `OFS_TXSTAT, {2'h0, ie, 5'h0});
      rd8(`OFS_TXSTAT, 8'hFF, {2'h0, ie, 5'h0}, "full");
      for (int k = 0; k < 10; k++)
      begin
        strobe();
        chk("txBit", 32'(bits[k]), 32'(txBit));
      end
      rd8(`OFS_TXSTAT, 8'hFF, {ie, 1'b0, ie, 5'h08}, "drained");
      chk("irq", 32'(ie), 32'(memBus.irq));
      chk("irqBit", 32'(ie), 32'(st[17]));
    end
    $display("transmit test done");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys);
      hdlcMode <= (i != 4); // holding already drained
      rxWindowVld <= (i != 1);
      rxFirstData <= (i == 1);
      rxWindow <= (i == 3) ? (8'h80 | 8'($random(seed))) : `HDLC_FLAG;
      @(posedge clk_sys);
      rxWindowVld <= 1'b0;
      rxFirstData <= 1'b0;
      rd8(`OFS_SYNC, 8'h01, {7'h0, i == 0 || i == 2},
          "flagSeen");
    end
    $display("sync test done");
    for (int i = 0; i < 3; i++)
    begin
      fifoModeOn <= 1'b1;
      fifoExtOn <= (i < 2);
      fifoRoom <= (i == 1);
      rd8(`OFS_TXSTAT, 8'h08, (i == 0) ? 8'h00 : 8'h08, "fifo");
    end
    fifoModeOn <= 1'b0;
    axi_wr(4'h4, 32'h0, r2);
    chk("badWrite", 32'(`AXI_SLVERR), 32'(r2));
    axi_rd(4'h8, st, r2);
    chk("badRead", 32'hDEAD0000, st);
    chk("rresp", 32'(`AXI_OKAY), 32'(r2));
    $display("bus test done");
    final_report();
  end
endmodule
`default_nettype wire

// file: verilog/host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "pump_if_cfg.svh"

module host_ctrl
  import pump_if_pkg::*;
(
  input  wire logic        clk_sys,      // 100 MHz system clock
  input  wire logic        rst,          // synchronous, active high
  pump_mem_if.host         mem,          // pump interface memory
  input  wire logic        dataMode,     // pump is in data mode
  input  wire logic        ctsOn,        // clear to send
  input  wire logic        rtsOn,        // request to send held
  input  wire logic        longTrainOk,  // a good long train finished
  input  wire logic        awvalid,      // axi write address valid
  output logic             awready,      // axi write address ready
  input  wire logic [3:0]  awaddr,       // axi write address
  input  wire logic        wvalid,       // axi write data valid
  output logic             wready,       // axi write data ready
  input  wire logic [31:0] wdata,        // axi write data
  input  wire logic [3:0]  wstrb,        // axi byte strobes
  output logic             bvalid,       // axi write response valid
  input  wire logic        bready,       // axi write response ready
  output logic [1:0]       bresp,        // axi write response
  input  wire logic        arvalid,      // axi read address valid
  output logic             arready,      // axi read address ready
  input  wire logic [3:0]  araddr,       // axi read address
  output logic             rvalid,       // axi read data valid
  input  wire logic        rready,       // axi read data ready
  output logic [31:0]      rdata,        // axi read data
  output logic [1:0]       rresp         // axi read response
);

  host_state_t s;       // registered state
  host_state_t next_s;  // next state

  logic        cmdGo;   // both write halves present
  logic [31:0] cmdWord; // write data as taken
  logic        okay;    // command passes the host checks
  logic [4:0]  cAddr;   // command fields
  logic        cRead;

  // command word: [16] read, [12:8] address, [7:0] data
  always_comb
  begin
    cmdWord = s.wData;
    cAddr   = cmdWord[12:8];
    cRead   = cmdWord[`CMD_RD_BIT];
    cmdGo   = s.awTaken && s.wTaken && !s.bvalid;
    okay    = 1'b1;
    if (cRead && cAddr == `OFS_TXHOLD && dataMode)
      okay = 1'b0;
    if (!cRead && cAddr == `OFS_TXHOLD && !(ctsOn && rtsOn))
      okay = 1'b0;
    if (!cRead && cAddr == `OFS_TRAIN && cmdWord[`BIT_SHORT_SEL]
        && !longTrainOk)
      okay = 1'b0;
    if (s.phase != H_IDLE)
      okay = 1'b0;
  end

  // next state
  always_comb
  begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    next_s.irqSeen = mem.irq;

    // write address and data taken in either order
    if (awvalid && !s.awTaken)
    begin
      next_s.awTaken = 1'b1;
      next_s.awAddr  = awaddr;
    end
    if (wvalid && !s.wTaken)
    begin
      next_s.wTaken = 1'b1;
      next_s.wData  = wstrb[0] ? wdata : 32'h0000_0000;
    end

    // act on a complete write
    if (cmdGo)
    begin
      next_s.awTaken = 1'b0;
      next_s.wTaken  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = `AXI_OKAY;
      if (s.awAddr != `HOST_OFS_CMD)
        next_s.bresp = `AXI_SLVERR;
      else if (okay)
      begin
        next_s.refused = 1'b0;
        next_s.isRead  = cRead;
        next_s.addr    = cAddr;
        next_s.wdata   = cmdWord[7:0];
        next_s.phase   = H_ISSUE;
      end
      else
      begin
        next_s.refused = 1'b1;
      end
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;

    // interface memory sequencer
    unique case (s.phase)
      H_IDLE:
        next_s.phase = next_s.phase;
      H_ISSUE:
      begin
        next_s.wr    = !s.isRead;
        next_s.rd    = s.isRead;
        next_s.phase = s.isRead ? H_WAIT : H_IDLE;
      end
      H_WAIT:
        if (mem.rdValid)
        begin
          next_s.lastRead = mem.rdata;
          next_s.phase    = H_IDLE;
        end
    endcase

    // axi read of controller registers
    if (arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = 32'h0000_0000;
      if (araddr == `HOST_OFS_STAT)
        next_s.rdata = {14'h0000, s.irqSeen, s.refused,
                        s.lastRead, 7'h00, s.phase != H_IDLE};
      else if (araddr != `HOST_OFS_CMD)
        next_s.rdata = 32'hDEAD_0000;
    end
    else if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
  end

  // register the state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  // outputs from flops, except rresp which is tied to AXI_OKAY
  assign awready   = !s.awTaken;
  assign wready    = !s.wTaken;
  assign bvalid    = s.bvalid;
  assign bresp     = s.bresp;
  assign arready   = !s.rvalid;
  assign rvalid    = s.rvalid;
  assign rdata     = s.rdata;
  assign rresp     = `AXI_OKAY;
  assign mem.addr  = s.addr;
  assign mem.wdata = s.wdata;
  assign mem.wr    = s.wr;
  assign mem.rd    = s.rd;

endmodule
`default_nettype wire

// file: verilog/pump_regs.sv
// Design decision made in the host controller: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pump_if_cfg.svh"

module pump_regs
  import pump_if_pkg::*;
(
  input  wire logic       clk_sys,     // 100 MHz system clock
  input  wire logic       rst,         // synchronous, active high
  pump_mem_if.pump        mem,         // host interface memory port
  input  wire logic       v17v27Sel,   // config is v.17 or v.27 ter
  input  wire logic       hdlcMode,    // hdlc framing selected
  input  wire logic       fifoModeOn,  // transmit fifo mode
  input  wire logic       fifoExtOn,   // long fifo extension on
  input  wire logic       fifoRoom,    // extension can take more
  input  wire logic       rxWindowVld, // rxWindow updated this cycle
  input  wire logic [7:0] rxWindow,    // last eight received bits
  input  wire logic       rxFirstData, // first data byte of frame in
  input  wire logic       txBitStrobe, // transmit bit time pulse
  output logic            txBit,       // serial transmit bit
  output logic [2:0]      toneEn,      // tone detector enables A..C
  output logic            shortTrain,  // 1 short, 0 long train
  output logic            tapsHold,    // keep equalizer taps
  output logic            shortAccept  // receiver may take short train
);

  pump_state_t s;       // registered state
  pump_state_t next_s;  // next state

  logic wrTone;         // write strobes per location
  logic wrTrain;
  logic wrHold;
  logic wrStat;
  logic emptyView;      // empty as the host sees it

  // write decode
  always_comb
  begin
    wrTone  = mem.wr && (mem.addr == `OFS_TONE);
    wrTrain = mem.wr && (mem.addr == `OFS_TRAIN);
    wrHold  = mem.wr && (mem.addr == `OFS_TXHOLD);
    wrStat  = mem.wr && (mem.addr == `OFS_TXSTAT);
  end

  // in fifo mode with the extension on the flag means room, not a truly empty fifo
  always_comb
  begin
    if (fifoModeOn && fifoExtOn)
      emptyView = fifoRoom;
    else
      emptyView = !s.holdFull;
  end

  // next state
  always_comb
  begin
    next_s = s;
    next_s.rdValid = 1'b0;

    // control bits
    if (wrTone)
      next_s.toneOn = mem.wdata[`BIT_TONE_ON];
    if (wrTrain)
      next_s.shortSel = mem.wdata[`BIT_SHORT_SEL];
    if (wrStat)
      next_s.irqOn = mem.wdata[`BIT_IRQ_ON];

    // serializer: a byte goes out lsb first, mark when nothing held
    if (txBitStrobe)
    begin
      if (s.busy)
      begin
        next_s.txBit   = s.shifter[0];
        next_s.shifter = {1'b0, s.shifter[7:1]};
        next_s.bitCnt  = s.bitCnt + 3'h1;
        next_s.busy    = (s.bitCnt != `LAST_BIT);
      end
      else if (s.holdFull)
      begin
        // taking the byte frees the holding location
        next_s.txBit    = s.txHold[0];
        next_s.shifter  = {1'b0, s.txHold[7:1]};
        next_s.bitCnt   = 3'h1;
        next_s.busy     = 1'b1;
        next_s.holdFull = 1'b0;
      end
      else
      begin
        next_s.txBit = `MARK_LEVEL;
      end
    end

    // host write refills the holding byte; a take in the same cycle
    // drained the old byte, so the new one must stay full
    if (wrHold)
    begin
      next_s.txHold   = mem.wdata;
      next_s.holdFull = 1'b1;
    end

    // active flag only when the enable is on
    if (wrHold)
      next_s.irqAct = 1'b0;
    else if (s.irqOn && emptyView)
      next_s.irqAct = 1'b1;
    else if (!s.irqOn)
      next_s.irqAct = s.irqAct;

    // request line is the one active flag gated by its enable
    next_s.irq = next_s.irqAct && next_s.irqOn;

    // flag detector, cleared by first data byte of the frame
    if (rxFirstData)
      next_s.flagSeen = 1'b0;
    else if (rxWindowVld)
      next_s.flagSeen = (rxWindow == `HDLC_FLAG);
    if (!hdlcMode)
      next_s.flagSeen = 1'b0;

    // training and detector controls
    next_s.shortTrain  = v17v27Sel && next_s.shortSel;
    next_s.tapsHold    = v17v27Sel && next_s.shortSel;
    next_s.shortAccept = next_s.shortSel;
    next_s.toneEn      = {3{next_s.toneOn}};

    // read path, answered one cycle after the strobe
    if (mem.rd)
    begin
      next_s.rdValid = 1'b1;
      next_s.rdata   = 8'h00;
      unique case (mem.addr)
        `OFS_TONE:
          next_s.rdata[`BIT_TONE_ON] = s.toneOn;
        `OFS_TRAIN:
          next_s.rdata[`BIT_SHORT_SEL] = s.shortSel;
        `OFS_SYNC:
          next_s.rdata[`BIT_FLAG_SEEN] = s.flagSeen;
        `OFS_TXHOLD:
          next_s.rdata = s.txHold;
        `OFS_TXSTAT:
        begin
          next_s.rdata[`BIT_IRQ_ACT] = s.irqAct;
          next_s.rdata[`BIT_IRQ_ON]  = s.irqOn;
          next_s.rdata[`BIT_EMPTY]   = emptyView;
        end
        default:
          next_s.rdata = 8'h00;                           // unmapped
      endcase
    end
  end

  // register the state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s             <= '0;
      s.txHold      <= `RST_TXHOLD;
      s.holdFull    <= !`RST_EMPTY;
      s.toneOn      <= `RST_TONE_ON;
      s.shortSel    <= `RST_SHORT_SEL;
      s.irqOn       <= `RST_IRQ_ON;
      s.txBit       <= `MARK_LEVEL;
      s.toneEn      <= {3{`RST_TONE_ON}};
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign mem.rdata   = s.rdata;
  assign mem.rdValid = s.rdValid;
  assign mem.irq     = s.irq;
  assign txBit       = s.txBit;
  assign toneEn      = s.toneEn;
  assign shortTrain  = s.shortTrain;
  assign tapsHold    = s.tapsHold;
  assign shortAccept = s.shortAccept;

endmodule
`default_nettype wire
